/* include/scr_pkg.sv */
// shared constants for the serial counter read and reset port
package scr_pkg;
	// frame layout
	localparam int          PRE_MIN_BITS  = 32;
	localparam logic [5:0]  PRE_MIN       = 6'h20;
	localparam logic [1:0]  START_PAT     = 2'h1;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_RESET      = 2'h1;
	localparam int          ADDR_W        = 7;
	localparam int          DEV_W         = 2;
	localparam int          IDX_W         = 6;
	localparam int          DATA_W        = 32;
	localparam int          HALF_W        = 16;
	localparam logic [5:0]  OP_LAST       = 6'h01;
	localparam logic [5:0]  ADDR_LAST     = 6'h06;
	localparam logic [5:0]  TA_LAST       = 6'h01;
	localparam logic [5:0]  DATA_LAST     = 6'h1f;
	localparam logic [5:0]  DEV_LAST      = 6'h01;
	localparam logic [5:0]  IDX_LAST      = 6'h05;
	localparam logic [6:0]  EE_ODD_BIT    = 7'h01;
	// status registers in the counter table
	localparam logic [6:0]  REG_CABLE     = 7'h03;
	localparam logic [6:0]  REG_OVF_RX    = 7'h3a;
	localparam logic [6:0]  REG_OVF_TX    = 7'h3b;
	localparam logic [6:0]  REG_OVF_CE    = 7'h3c;
	localparam int          CBL_PORTS     = 5;
	localparam int          PORTS         = 6;
	localparam int          KINDS         = 6;
	localparam int          OVF_WORDS     = 3;
	localparam int          CBL_LEN_POS [CBL_PORTS] = '{0, 6, 12, 18, 21};
	localparam int          CBL_FLG_POS [CBL_PORTS] = '{2, 8, 14, 20, 23};
	localparam int          OVF_PKT_POS [PORTS]     = '{0, 2, 4, 6, 7, 8};
	localparam int          OVF_BYTE_POS[PORTS]     = '{9, 11, 13, 15, 16, 17};
	// host side timing and command port
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          LINK_PERIOD_NS = 1600;
	localparam logic [3:0]  LINK_HALF_LAST = 4'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS) - 1);
	localparam logic [5:0]  READ_BITS      = 6'h2c;
	localparam logic [5:0]  RESET_BITS     = 6'h2d;
	localparam logic [5:0]  HOST_TA_LAST   = 6'h02;
	localparam logic [5:0]  HOST_GAP_LAST  = 6'h02;
	localparam logic [31:0] PREAMBLE       = 32'hffff_ffff;
	localparam int          HA_W           = 8;
	localparam logic [7:0]  HREG_CMD       = 8'h00;
	localparam logic [7:0]  HREG_STATUS    = 8'h04;
	localparam logic [7:0]  HREG_RDATA     = 8'h08;
	localparam int          CMD_KIND_BIT   = 0;
	localparam int          CMD_SEL_BIT    = 1;
	localparam int          CMD_ADDR_LSB   = 2;
	localparam int          CMD_DEV_LSB    = 9;
	localparam int          CMD_W          = 11;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_DONE_BIT  = 1;
endpackage

/* include/scr_link_if.sv */
// serial management link between host and device
`timescale 1ns/1ps
interface scr_link_if;
	logic serial_mgmt_clock;
	logic serial_chip_select_n;
	logic serial_mgmt_data;
	logic host_data;
	logic host_data_oe;
	logic dev_data;
	logic dev_data_oe;

	// resolved data wire, pulled up when nobody drives
	assign serial_mgmt_data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 1'h1);

	modport dev (
		input  serial_mgmt_clock,
		input  serial_chip_select_n,
		input  serial_mgmt_data,
		output dev_data,
		output dev_data_oe
	);
	modport host (
		output serial_mgmt_clock,
		output serial_chip_select_n,
		output host_data,
		output host_data_oe,
		input  serial_mgmt_data
	);
endinterface

/* verilog/scr_dev.sv */
// device end: serial counter read and counter reset slave
`timescale 1ns/1ps
module scr_dev (
	input  wire logic                           mclk_i,
	input  wire logic                           reset_n_i,
	scr_link_if.dev                             link,
	input  wire logic [scr_pkg::DEV_W-1:0]      chip_addr_strap_i,
	output logic      [scr_pkg::ADDR_W-1:0]     counter_addr_o,
	input  wire logic [scr_pkg::DATA_W-1:0]     counter_data_i,
	output logic      [scr_pkg::ADDR_W-1:0]     ee_addr_hi_o,
	output logic      [scr_pkg::ADDR_W-1:0]     ee_addr_lo_o,
	input  wire logic [scr_pkg::HALF_W-1:0]     ee_data_hi_i,
	input  wire logic [scr_pkg::HALF_W-1:0]     ee_data_lo_i,
	input  wire logic [scr_pkg::KINDS-1:0][scr_pkg::PORTS-1:0] ovf_evt_i,
	input  wire logic [scr_pkg::CBL_PORTS-1:0][1:0] cable_len_i,
	input  wire logic [scr_pkg::CBL_PORTS-1:0]  cable_fault_i,
	output logic                                clr_pulse_o,
	output logic                                clr_by_port_o,
	output logic      [scr_pkg::IDX_W-1:0]      clr_index_o
);
	import scr_pkg::*;

	typedef enum logic [3:0] {
		ST_PRE, ST_START, ST_OP, ST_TSEL, ST_ADDR, ST_TA, ST_DATA, ST_RDEV, ST_RTYPE, ST_RIDX
	} scr_dev_st_t;

	logic [1:0]              clk_sy_q;
	logic [1:0]              dat_sy_q;
	logic [1:0]              cs_sy_q;
	logic                    clk_prev_q;
	logic                    rise;
	logic                    fall;
	logic                    din;
	logic                    cs_off;
	logic [DEV_W-1:0]        strap_sy_q;
	logic [DEV_W-1:0]        strap_q;
	scr_dev_st_t             st_q;
	logic [5:0]              cnt_q;
	logic [5:0]              ones_q;
	logic [1:0]              op_q;
	logic                    tsel_q;
	logic [ADDR_W-1:0]       addr_q;
	logic [DEV_W-1:0]        dev_q;
	logic                    rtype_q;
	logic [IDX_W-1:0]        idx_q;
	logic [DATA_W-1:0]       sh_q;
	logic                    sdo_q;
	logic                    oe_q;
	logic [DATA_W-1:0]       rd_word;
	logic [DATA_W-1:0]       cable_word;
	logic [DATA_W-1:0]       ovf_word [OVF_WORDS];
	logic [CBL_PORTS-1:0][1:0] cable_len_q;
	logic [CBL_PORTS-1:0]    cable_fault_q;
	logic                    ovf_q [KINDS][PORTS];
	logic                    clr_pulse_q;
	logic                    clr_by_port_q;
	logic [IDX_W-1:0]        clr_index_q;
	logic [ADDR_W-1:0]       ee_hi_q;
	logic [ADDR_W-1:0]       ee_lo_q;

	// two-flop synchronisers for the link pins
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clk_sy_q   <= 2'h0;
			dat_sy_q   <= 2'h3;
			cs_sy_q    <= 2'h3;
			clk_prev_q <= 1'h0;
		end else begin
			clk_sy_q   <= {clk_sy_q[0], link.serial_mgmt_clock};
			dat_sy_q   <= {dat_sy_q[0], link.serial_mgmt_data};
			cs_sy_q    <= {cs_sy_q[0], link.serial_chip_select_n};
			clk_prev_q <= clk_sy_q[1];
		end
	end

	assign rise   = clk_sy_q[1] & ~clk_prev_q;
	assign fall   = ~clk_sy_q[1] & clk_prev_q;
	assign din    = dat_sy_q[1];
	assign cs_off = cs_sy_q[1];

	// strap pins through two flops
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_sy_q <= 2'h0;
			strap_q    <= 2'h0;
		end else begin
			strap_sy_q <= chip_addr_strap_i;
			strap_q    <= strap_sy_q;
		end
	end

	// frame decoder, advances on serial clock rises
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q    <= ST_PRE;
			cnt_q   <= 6'h00;
			ones_q  <= 6'h00;
			op_q    <= 2'h0;
			tsel_q  <= 1'h0;
			addr_q  <= 7'h00;
			dev_q   <= 2'h0;
			rtype_q <= 1'h0;
			idx_q   <= 6'h00;
		end else if (cs_off) begin
			st_q   <= ST_PRE;
			ones_q <= 6'h00;
			cnt_q  <= 6'h00;
		end else if (rise) begin
			case (st_q)
				ST_PRE: begin
					if (din) begin
						if (ones_q != PRE_MIN) begin
							ones_q <= ones_q + 6'h01;
						end
					end else if (ones_q == PRE_MIN) begin
						st_q <= ST_START;
					end else begin
						ones_q <= 6'h00;
					end
				end
				ST_START: begin
					ones_q <= 6'h00;
					cnt_q  <= 6'h00;
					st_q   <= din ? ST_OP : ST_PRE;
				end
				ST_OP: begin
					op_q  <= {op_q[0], din};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == OP_LAST) begin
						cnt_q <= 6'h00;
						case ({op_q[0], din})
							OP_READ:  st_q <= ST_TSEL;
							OP_RESET: st_q <= ST_RDEV;
							default:  st_q <= ST_PRE;
						endcase
					end
				end
				ST_TSEL: begin
					tsel_q <= din;
					st_q   <= ST_ADDR;
				end
				ST_ADDR: begin
					addr_q <= {addr_q[ADDR_W-2:0], din};
					cnt_q  <= cnt_q + 6'h01;
					if (cnt_q == ADDR_LAST) begin
						cnt_q <= 6'h00;
						st_q  <= ST_TA;
					end
				end
				ST_TA: begin
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == TA_LAST) begin
						cnt_q <= 6'h00;
						st_q  <= ST_DATA;
					end
				end
				ST_DATA: begin
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == DATA_LAST) begin
						cnt_q <= 6'h00;
						st_q  <= ST_PRE;
					end
				end
				ST_RDEV: begin
					dev_q <= {dev_q[0], din};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == DEV_LAST) begin
						cnt_q <= 6'h00;
						st_q  <= ST_RTYPE;
					end
				end
				ST_RTYPE: begin
					rtype_q <= din;
					st_q    <= ST_RIDX;
				end
				ST_RIDX: begin
					idx_q <= {idx_q[IDX_W-2:0], din};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == IDX_LAST) begin
						cnt_q <= 6'h00;
						st_q  <= ST_PRE;
					end
				end
				default: st_q <= ST_PRE;
			endcase
		end
	end

	// counter clear command
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clr_pulse_q   <= 1'h0;
			clr_by_port_q <= 1'h0;
			clr_index_q   <= 6'h00;
		end else begin
			clr_pulse_q <= !cs_off && rise && st_q == ST_RIDX && cnt_q == IDX_LAST
				&& dev_q == strap_q;
			if (!cs_off && rise && st_q == ST_RIDX && cnt_q == IDX_LAST) begin
				clr_by_port_q <= rtype_q;
				clr_index_q   <= {idx_q[IDX_W-2:0], din};
			end
		end
	end

	assign clr_pulse_o   = clr_pulse_q;
	assign clr_by_port_o = clr_by_port_q;
	assign clr_index_o   = clr_index_q;

	// read data shifter, loaded on the last turnaround rise, shifts out after serial clock falls
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sh_q  <= 32'h0000_0000;
			sdo_q <= 1'h1;
			oe_q  <= 1'h0;
		end else if (cs_off) begin
			oe_q <= 1'h0;
		end else if (rise && st_q == ST_TA && cnt_q == TA_LAST) begin
			sh_q <= rd_word;
		end else if (fall) begin
			if (st_q == ST_DATA) begin
				oe_q  <= 1'h1;
				sdo_q <= sh_q[DATA_W-1];
				sh_q  <= {sh_q[DATA_W-2:0], 1'h0};
			end else begin
				oe_q <= 1'h0;
			end
		end
	end

	assign link.dev_data    = sdo_q;
	assign link.dev_data_oe = oe_q;

	// lookup addresses
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ee_hi_q <= 7'h00;
			ee_lo_q <= 7'h00;
		end else begin
			ee_hi_q <= addr_q | EE_ODD_BIT;
			ee_lo_q <= addr_q & ~EE_ODD_BIT;
		end
	end

	assign counter_addr_o = addr_q;
	assign ee_addr_hi_o   = ee_hi_q;
	assign ee_addr_lo_o   = ee_lo_q;

	// cable fault status sampling
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cable_len_q   <= '0;
			cable_fault_q <= '0;
		end else begin
			cable_len_q   <= cable_len_i;
			cable_fault_q <= cable_fault_i;
		end
	end

	// sticky overflow flags, event wins over clear
	for (genvar k = 0; k < KINDS; k++) begin : g_kind
		for (genvar p = 0; p < PORTS; p++) begin : g_port
			always_ff @(posedge mclk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					ovf_q[k][p] <= 1'h0;
				end else if (ovf_evt_i[k][p]) begin
					ovf_q[k][p] <= 1'h1;
				end else if (clr_pulse_q && (clr_by_port_q ? clr_index_q == IDX_W'(p)
						: clr_index_q == IDX_W'(k * PORTS + p))) begin
					ovf_q[k][p] <= 1'h0;
				end
			end
		end
	end

	// status word assembly
	always_comb begin
		cable_word = '0;
		for (int p = 0; p < CBL_PORTS; p++) begin
			cable_word[CBL_LEN_POS[p] +: 2] = cable_len_q[p];
			cable_word[CBL_FLG_POS[p]]      = cable_fault_q[p];
		end
		for (int w = 0; w < OVF_WORDS; w++) begin
			ovf_word[w] = '0;
			for (int p = 0; p < PORTS; p++) begin
				ovf_word[w][OVF_PKT_POS[p]]  = ovf_q[2 * w][p];
				ovf_word[w][OVF_BYTE_POS[p]] = ovf_q[2 * w + 1][p];
			end
		end
	end

	// read source select
	always_comb begin
		if (tsel_q) begin
			case (addr_q)
				REG_CABLE:  rd_word = cable_word;
				REG_OVF_RX: rd_word = ovf_word[0];
				REG_OVF_TX: rd_word = ovf_word[1];
				REG_OVF_CE: rd_word = ovf_word[2];
				default:    rd_word = counter_data_i;
			endcase
		end else begin
			rd_word = {ee_data_hi_i, ee_data_lo_i};
		end
	end
endmodule

/* verilog/scr_host.sv */
// host end: drives read and reset frames from a register port
`timescale 1ns/1ps
module scr_host (
	input  wire logic                       mclk_i,
	input  wire logic                       reset_n_i,
	scr_link_if.host                        link,
	input  wire logic [scr_pkg::HA_W-1:0]   addr_i,
	input  wire logic [31:0]                wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [31:0]                rdata_o
);
	import scr_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_OUT, H_TA, H_IN, H_GAP} scr_host_st_t;

	scr_host_st_t      st_q;
	logic [3:0]        div_q;
	logic              sclk_q;
	logic              tick;
	logic              rise;
	logic              fall;
	logic [1:0]        din_sy_q;
	logic [63:0]       sh_q;
	logic [5:0]        cnt_q;
	logic [5:0]        nbits_q;
	logic              is_read_q;
	logic              sdo_q;
	logic              oe_q;
	logic [CMD_W-1:0]  cmd_q;
	logic [31:0]       rsh_q;
	logic [31:0]       rdat_q;
	logic              done_q;
	logic [31:0]       rdata_q;
	logic              start;

	// link clock divider, free running
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_q  <= 4'h0;
			sclk_q <= 1'h0;
		end else if (div_q == LINK_HALF_LAST) begin
			div_q  <= 4'h0;
			sclk_q <= ~sclk_q;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	assign tick = div_q == LINK_HALF_LAST;
	assign rise = tick & ~sclk_q;
	assign fall = tick & sclk_q;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			din_sy_q <= 2'h3;
		end else begin
			din_sy_q <= {din_sy_q[0], link.serial_mgmt_data};
		end
	end

	assign start = wr_i && addr_i == HREG_CMD && st_q == H_IDLE;

	// frame sequencer
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q      <= H_IDLE;
			sh_q      <= 64'h0000_0000_0000_0000;
			cnt_q     <= 6'h00;
			nbits_q   <= 6'h00;
			is_read_q <= 1'h0;
			sdo_q     <= 1'h1;
			oe_q      <= 1'h0;
			cmd_q     <= '0;
			rsh_q     <= 32'h0000_0000;
			rdat_q    <= 32'h0000_0000;
			done_q    <= 1'h0;
		end else if (start) begin
			cmd_q     <= wdata_i[CMD_W-1:0];
			done_q    <= 1'h0;
			cnt_q     <= 6'h00;
			st_q      <= H_OUT;
			is_read_q <= ~wdata_i[CMD_KIND_BIT];
			if (wdata_i[CMD_KIND_BIT]) begin
				nbits_q <= RESET_BITS;
				sh_q    <= {PREAMBLE, START_PAT, OP_RESET,
					wdata_i[CMD_DEV_LSB +: DEV_W], wdata_i[CMD_SEL_BIT],
					wdata_i[CMD_ADDR_LSB +: IDX_W], 19'h0_0000};
			end else begin
				nbits_q <= READ_BITS;
				sh_q    <= {PREAMBLE, START_PAT, OP_READ, wdata_i[CMD_SEL_BIT],
					wdata_i[CMD_ADDR_LSB +: ADDR_W], 20'h0_0000};
			end
		end else begin
			case (st_q)
				H_IDLE: oe_q <= 1'h0;
				H_OUT: begin
					if (fall) begin
						if (cnt_q == nbits_q) begin
							oe_q  <= 1'h0;
							cnt_q <= 6'h01;
							st_q  <= is_read_q ? H_TA : H_GAP;
						end else begin
							oe_q  <= 1'h1;
							sdo_q <= sh_q[63];
							sh_q  <= {sh_q[62:0], 1'h0};
							cnt_q <= cnt_q + 6'h01;
						end
					end
				end
				H_TA: begin
					if (fall) begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == HOST_TA_LAST) begin
							cnt_q <= 6'h00;
							st_q  <= H_IN;
						end
					end
				end
				H_IN: begin
					if (rise) begin
						rsh_q <= {rsh_q[30:0], din_sy_q[1]};
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == DATA_LAST) begin
							rdat_q <= {rsh_q[30:0], din_sy_q[1]};
							cnt_q  <= 6'h00;
							st_q   <= H_GAP;
						end
					end
				end
				H_GAP: begin
					if (fall) begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q == HOST_GAP_LAST) begin
							st_q   <= H_IDLE;
							done_q <= 1'h1;
						end
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	assign link.serial_mgmt_clock    = sclk_q;
	assign link.serial_chip_select_n = st_q == H_IDLE;
	assign link.host_data            = sdo_q;
	assign link.host_data_oe         = oe_q;

	// register read port, data one cycle later
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_i) begin
			case (addr_i)
				HREG_CMD:    rdata_q <= 32'(cmd_q);
				HREG_STATUS: rdata_q <= 32'({done_q, st_q != H_IDLE});
				HREG_RDATA:  rdata_q <= rdat_q;
				default:     rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign rdata_o = rdata_q;
endmodule

/* dv/scr_link_properties.sv */
// checker: properties of the serial link between host and device
`timescale 1ns/1ps
module scr_link_properties
	import scr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic serial_mgmt_clock,
	input wire logic serial_chip_select_n,
	input wire logic serial_mgmt_data,
	input wire logic host_data,
	input wire logic host_data_oe,
	input wire logic dev_data,
	input wire logic dev_data_oe
);
	localparam int PER = LINK_PERIOD_NS / CLK_PERIOD_NS;
	logic       sck_q;
	logic       zero_q;
	logic       rise;
	logic [5:0] ones_q;
	logic [9:0] oe_q;
	logic [7:0] gap_q;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	assign rise = serial_mgmt_clock & ~sck_q;
	// serial clock edge, drive lengths
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sck_q <= 1'b0;
			oe_q  <= '0;
			gap_q <= '0;
		end else begin
			sck_q <= serial_mgmt_clock;
			oe_q  <= dev_data_oe ? oe_q + 10'h001 : '0;
			gap_q <= host_data_oe ? '0 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
		end
	end
	// leading ones of a frame
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ones_q <= '0;
			zero_q <= 1'b0;
		end else if (serial_chip_select_n) begin
			ones_q <= '0;
			zero_q <= 1'b0;
		end else if (rise && host_data_oe) begin
			if (!serial_mgmt_data) begin
				zero_q <= 1'b1;
			end else if (!zero_q && ones_q != 6'h3f) begin
				ones_q <= ones_q + 6'h01;
			end
		end
	end
	AST_ONE_DRIVER: assert property (!(host_data_oe && dev_data_oe))
		else $error("host and device drive data together");
	AST_DEV_SELECTED: assert property (dev_data_oe |-> !serial_chip_select_n)
		else $error("device drives data while deselected");
	AST_DEV_EDGE: assert property (
		dev_data_oe && $changed(dev_data) |-> !serial_mgmt_clock)
		else $error("device data changed while serial clock high");
	AST_HOST_EDGE: assert property (
		host_data_oe && $changed(host_data) |-> !serial_mgmt_clock)
		else $error("host data changed while serial clock high");
	AST_PREAMBLE: assert property (
		rise && host_data_oe && !serial_mgmt_data && !zero_q |-> ones_q >= 6'h20)
		else $error("frame started with short run of ones");
	AST_DATA_LEN: assert property (
		$fell(dev_data_oe) |-> oe_q >= 10'(32 * PER - 8) && oe_q <= 10'(32 * PER + 8))
		else $error("device drove data for wrong length");
	AST_TURNAROUND: assert property (
		$rose(dev_data_oe) |-> gap_q >= 8'(2 * PER - 4) && gap_q <= 8'(2 * PER + 8))
		else $error("turnaround length wrong");
	AST_IDLE_CLOCK: assert property (
		$rose(serial_chip_select_n) |-> ##[1:16] $rose(serial_mgmt_clock))
		else $error("no serial clock in idle gap");
	cover property ($fell(dev_data_oe));
	cover property ($rose(serial_chip_select_n));
	cover property (rise && host_data_oe && !serial_mgmt_data && !zero_q);
endmodule

/* dv/tb.sv */
// testbench: host and device ends joined, driven over the register port
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; \
	if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
	import scr_pkg::*;
	logic                        mclk_i, reset_n_i, wr_i, rd_i, rchk, rchk_d;
	logic                        clr_pulse_o, clr_by_port_o;
	logic [HA_W-1:0]             addr_i;
	logic [31:0]                 wdata_i, rdata_o, exp_r, ex, counter_data_i;
	logic [DEV_W-1:0]            chip_addr_strap_i;
	logic [ADDR_W-1:0]           counter_addr_o, ee_addr_hi_o, ee_addr_lo_o, a;
	logic [HALF_W-1:0]           ee_data_hi_i, ee_data_lo_i;
	logic [KINDS-1:0][PORTS-1:0] ovf_evt_i, fl;
	logic [CBL_PORTS-1:0][1:0]   cable_len_i;
	logic [CBL_PORTS-1:0]        cable_fault_i;
	logic [IDX_W-1:0]            clr_index_o;
	logic [6:0]                  exp_c;
	logic [24:0]                 cbase;
	logic [8:0]                  ebase;
	logic [31:0]                 exq[$];
	logic [6:0]                  clq[$];
	logic [6:0]                  eel[6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h7e, 7'h7f};
	int                          errors, compares, seed;

	scr_link_if scr_link_if_i ();
	scr_dev scr_dev_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(scr_link_if_i),
		.chip_addr_strap_i(chip_addr_strap_i), .counter_addr_o(counter_addr_o),
		.counter_data_i(counter_data_i), .ee_addr_hi_o(ee_addr_hi_o),
		.ee_addr_lo_o(ee_addr_lo_o), .ee_data_hi_i(ee_data_hi_i), .ee_data_lo_i(ee_data_lo_i),
		.ovf_evt_i(ovf_evt_i), .cable_len_i(cable_len_i), .cable_fault_i(cable_fault_i),
		.clr_pulse_o(clr_pulse_o), .clr_by_port_o(clr_by_port_o), .clr_index_o(clr_index_o));
	scr_host scr_host_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(scr_link_if_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	scr_link_properties scr_link_properties_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.serial_mgmt_clock(scr_link_if_i.serial_mgmt_clock),
		.serial_chip_select_n(scr_link_if_i.serial_chip_select_n),
		.serial_mgmt_data(scr_link_if_i.serial_mgmt_data),
		.host_data(scr_link_if_i.host_data), .host_data_oe(scr_link_if_i.host_data_oe),
		.dev_data(scr_link_if_i.dev_data), .dev_data_oe(scr_link_if_i.dev_data_oe));

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	// counter table and eeprom lookups
	always @(posedge mclk_i) begin
		counter_data_i <= {cbase, counter_addr_o};
		ee_data_hi_i <= {ebase, ee_addr_hi_o};
		ee_data_lo_i <= {ebase, ee_addr_lo_o};
	end
	// output watcher
	always @(posedge mclk_i) begin
		rchk_d <= rd_i & rchk;
		if (rchk_d) begin
			exp_r = exq.pop_front();
			`CHK("rdata", exp_r, rdata_o)
		end
		if (clr_pulse_o === 1'b1) begin
			exp_c = (clq.size() != 0) ? clq.pop_front() : 7'h7f;
			`CHK("clear", exp_c, {clr_by_port_o, clr_index_o})
		end
	end

	task stop_test();
		$display("counts: compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic c);
		@(posedge mclk_i);
		addr_i <= ad;
		wdata_i <= d;
		wr_i <= w;
		rd_i <= !w;
		rchk <= c;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		rchk <= 1'b0;
	endtask
	task wait_done();
		int n;
		n = 0;
		do begin
			bus(1'b0, HREG_STATUS, '0, 1'b0);
			@(negedge mclk_i);
			n++;
		end while (rdata_o[1:0] !== 2'b10 && n < 3000);
		if (n >= 3000) begin
			errors++;
			stop_test();
		end
	endtask
	task rd_frame(input logic s, input logic [6:0] ad, input logic [31:0] e);
		bus(1'b1, HREG_CMD, {21'h0, 2'h0, ad, s, 1'b0}, 1'b0);
		wait_done();
		exq.push_back(e);
		bus(1'b0, HREG_RDATA, '0, 1'b1);
	endtask
	task rs_frame(input logic [1:0] d, input logic t, input logic [5:0] x);
		if (d === chip_addr_strap_i) clq.push_back({t, x});
		bus(1'b1, HREG_CMD, {21'h0, d, 1'b0, x, t, 1'b1}, 1'b0);
		wait_done();
		if (d === chip_addr_strap_i && t) for (int k = 0; k < KINDS; k++) fl[k][x] = 1'b0;
		if (d === chip_addr_strap_i && !t) fl[x / 6][x % 6] = 1'b0;
	endtask
	function automatic logic [31:0] ovf_word(input int w);
		logic [31:0] r;
		r = '0;
		for (int p = 0; p < PORTS; p++) begin
			r[OVF_PKT_POS[p]] = fl[2 * w][p];
			r[OVF_BYTE_POS[p]] = fl[2 * w + 1][p];
		end
		return r;
	endfunction
	task ovf_check();
		for (int w = 0; w < OVF_WORDS; w++) rd_frame(1'b1, REG_OVF_RX + 7'(w), ovf_word(w));
	endtask

	initial begin
		repeat (100000) @(posedge mclk_i);
		errors++;
		stop_test();
	end
	initial begin
		seed = 79;
		errors = 0;
		compares = 0;
		fl = '0;
		{reset_n_i, wr_i, rd_i, rchk, addr_i, wdata_i} = '0;
		ovf_evt_i = '0;
		{cable_len_i, cable_fault_i} = '0;
		cbase = 25'($random(seed));
		ebase = 9'($random(seed));
		chip_addr_strap_i = 2'($random(seed));
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		rd_frame(1'b1, REG_CABLE, '0);
		ovf_check();
		$display("test reset_values end");
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'h40 | 7'($random(seed) & 31);
			rd_frame(1'b1, a, {cbase, a});
		end
		$display("test counter_read end");
		foreach (eel[i]) begin
			a = eel[i];
			rd_frame(1'b0, a, a[0] ? {ebase, a, ebase, a - 7'h1} : {ebase, a + 7'h1, ebase, a});
		end
		$display("test eeprom_read end");
		cable_len_i <= 10'($random(seed));
		cable_fault_i <= 5'($random(seed));
		@(posedge mclk_i);
		ex = '0;
		for (int p = 0; p < CBL_PORTS; p++) begin
			ex[CBL_LEN_POS[p] +: 2] = cable_len_i[p];
			ex[CBL_FLG_POS[p]] = cable_fault_i[p];
		end
		rd_frame(1'b1, REG_CABLE, ex);
		$display("test cable_status end");
		repeat (3) begin
			@(posedge mclk_i);
			ex = $random(seed);
			ovf_evt_i <= 36'({ex, 4'($random(seed))});
			@(posedge mclk_i);
			fl = fl | ovf_evt_i;
			ovf_evt_i <= '0;
		end
		ovf_check();
		$display("test overflow_flags end");
		rs_frame(chip_addr_strap_i, 1'b1, 6'($unsigned($random(seed)) % 6));
		rs_frame(chip_addr_strap_i, 1'b0, 6'($unsigned($random(seed)) % 36));
		rs_frame(~chip_addr_strap_i, 1'b1, 6'h00);
		ovf_check();
		$display("test counter_clear end");
		bus(1'b1, HREG_RDATA, 32'hdead_beef, 1'b0);
		exq.push_back(ovf_word(2));
		bus(1'b0, HREG_RDATA, '0, 1'b1);
		exq.push_back('0);
		bus(1'b0, 8'h0c, '0, 1'b1);
		clq.push_back({1'b1, 6'h01});
		bus(1'b1, HREG_CMD, {21'h0, chip_addr_strap_i, 1'b0, 6'h01, 1'b1, 1'b1}, 1'b0);
		bus(1'b1, HREG_CMD, {21'h0, chip_addr_strap_i, 1'b0, 6'h02, 1'b1, 1'b1}, 1'b0);
		wait_done();
		for (int k = 0; k < KINDS; k++) fl[k][1] = 1'b0;
		ovf_check();
		repeat (4) @(posedge mclk_i);
		`CHK("queues", 1'b1, clq.size() == 0 && exq.size() == 0)
		$display("test refusals end");
		stop_test();
	end
endmodule
